// File: rtl/fatc_top.sv
// Feature access control register and trap decision logic
//
// Notes on behaviour
// - With level 2 hosting and general trapping, level 2 controls replace these fields.
// - Trace bit set traps all level 0/1 trace register accesses.
// - Trace traps report class 0x18, 0x05 single, 0x0C paired.
// - Trapped trace accesses have no side effects before exception.
// - Forbidden level 0 trace access is undefined, above trace trap.
// - Memory-mapped trace accesses are never trapped here.
// - Without trace system registers the trace bit reads zero.
// - Matrix field gates matrix, streaming vector and control register accesses.
// - Immediate streaming-mode writes trap alongside streaming control accesses.
// - Matrix traps report class 0x1D with zero syndrome detail.
// - Two-bit fields: 00/10 trap both, 01 level 0, 11 none.
// - Matrix trap beats floating-point trap.
// - Matrix field never affects streaming register validity.
// - Float field traps float registers; class 0x07, or 0x00 to level 2.
// - Float field also traps matrix and vector instructions, class 0x07.
// - Vector trap beats floating-point trap.
// - Level 0 float identification accesses undefined, above float trap.
// - Vector field traps non-streaming vector and vector control, class 0x19.
// - Level 0 register access undefined; level 1 traps to level 2 if enabled.
// - Nested virtualisation all set redirects level 1 access to offset 0x100.
// - Level 2 with hosting redirects this encoding to level 2 trap register.
// - Level 3 trap bit traps level 1/2 access; halted with disable is undefined.
module fatc_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chk_req,
  input wire fatc_pkg::fatc_insn_t chk_insn,
  input wire fatc_pkg::fatc_ctx_t chk_ctx,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [63:0] reg_wdata,
  input wire logic [63:0] el2_feature_trap,
  output logic [63:0] reg_rdata,
  output fatc_pkg::fatc_result_t chk_result,
  output fatc_pkg::fatc_result_t reg_result,
  output logic side_effect_en
);
  import fatc_pkg::*;
  `include "fatc_params.svh"

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [63:0] fac_q;
  logic [63:0] ctl_eff;
  logic [63:0] wr_mask;
  logic acc_ok;
  logic [1:0] acc_target;
  logic acc_undef;
  logic acc_trap;
  logic acc_nv;
  logic acc_el2;

  // Trace bit does not exist when trace system registers are absent
  assign wr_mask = chk_ctx.trace_sysreg_impl ? `FATC_WR_MASK : `FATC_WR_MASK_NOTRACE;

  // Writes land only when no trap, undefined or redirect applies; reserved bits dropped
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fac_q <= `FATC_RESET_VAL;
    end else if (reg_wr && acc_ok) begin
      fac_q <= reg_wdata & wr_mask;
    end
  end

  // Level 2 hosting with general trapping swaps in the level 2 controls
  always_comb begin
    if (chk_ctx.el2_present && chk_ctx.el2_enabled && chk_ctx.host_at_el2 &&
        chk_ctx.trap_general_exc) begin
      ctl_eff = el2_feature_trap;
    end else begin
      ctl_eff = fac_q & wr_mask;
    end
  end

  // ----------------------------------------------------------------
  // Register access checks
  // ----------------------------------------------------------------
  // Priority follows the system register access order for each level
  always_comb begin
    acc_undef = 1'b0;
    acc_trap = 1'b0;
    acc_target = 2'd0;
    acc_nv = 1'b0;
    acc_el2 = 1'b0;
    case (chk_ctx.level)
      2'd0: begin
        acc_undef = 1'b1;
      end
      2'd1: begin
        if (chk_ctx.halted && chk_ctx.el3_present && chk_ctx.debug_secure_disable &&
            chk_ctx.el3_sdd_priority && chk_ctx.el3_access_ctl_reg_trap) begin
          acc_undef = 1'b1;
        end else if (chk_ctx.el2_enabled && chk_ctx.el2_access_ctl_reg_trap) begin
          acc_trap = 1'b1;
          acc_target = 2'd2;
        end else if (chk_ctx.el3_present && chk_ctx.el3_access_ctl_reg_trap) begin
          if (chk_ctx.halted && chk_ctx.debug_secure_disable) begin
            acc_undef = 1'b1;
          end else begin
            acc_trap = 1'b1;
            acc_target = 2'd3;
          end
        end else if (chk_ctx.el2_enabled && chk_ctx.nested_virt == 3'b111) begin
          acc_nv = 1'b1;
        end
      end
      2'd2: begin
        if (chk_ctx.halted && chk_ctx.el3_present && chk_ctx.debug_secure_disable &&
            chk_ctx.el3_sdd_priority && chk_ctx.el3_access_ctl_reg_trap) begin
          acc_undef = 1'b1;
        end else if (chk_ctx.el3_present && chk_ctx.el3_access_ctl_reg_trap) begin
          if (chk_ctx.halted && chk_ctx.debug_secure_disable) begin
            acc_undef = 1'b1;
          end else begin
            acc_trap = 1'b1;
            acc_target = 2'd3;
          end
        end else if (chk_ctx.host_at_el2) begin
          acc_el2 = 1'b1;
        end
      end
      default: begin
        acc_undef = 1'b0;
      end
    endcase
  end

  assign acc_ok = !acc_undef && !acc_trap && !acc_nv && !acc_el2;

  // Register access answer, one cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_result <= '0;
      reg_rdata <= 64'h0;
    end else begin
      reg_result.valid <= reg_rd || reg_wr;
      reg_result.undef <= acc_undef;
      reg_result.trap <= acc_trap;
      reg_result.target <= acc_target;
      reg_result.ec <= acc_trap ? `FATC_EC_SYSREG : 6'h00;
      reg_result.syndrome <= `FATC_SYNDROME_ZERO;
      reg_result.suppress <= acc_undef || acc_trap;
      reg_result.redirect_nv <= acc_nv;
      reg_result.redirect_el2 <= acc_el2;
      reg_result.nv_offset <= acc_nv ? `FATC_NV_MEM_OFFSET : 12'h000;
      if (reg_rd && acc_el2) begin
        reg_rdata <= el2_feature_trap;
      end else if (reg_rd && acc_ok) begin
        reg_rdata <= fac_q & wr_mask;
      end else begin
        reg_rdata <= 64'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Instruction trap checks
  // ----------------------------------------------------------------
  logic low_level;
  logic mat_field_trap;
  logic flt_field_trap;
  logic vec_field_trap;
  logic trace_hit;
  logic mat_hit;
  logic flt_hit;
  logic vec_hit;
  logic flt_undef;
  logic trace_undef;
  logic [1:0] trap_target;
  fatc_result_t res_d;

  assign low_level = (chk_ctx.level <= 2'd1);

  // Matrix field decode; the field is never fed to register validity logic
  fatc_field_decode u_mat_dec (
    .field(ctl_eff[`FATC_MATRIX_HI:`FATC_MATRIX_LO]),
    .level(chk_ctx.level),
    .trap(mat_field_trap)
  );

  fatc_field_decode u_flt_dec (
    .field(ctl_eff[`FATC_FLOAT_HI:`FATC_FLOAT_LO]),
    .level(chk_ctx.level),
    .trap(flt_field_trap)
  );

  fatc_field_decode u_vec_dec (
    .field(ctl_eff[`FATC_VECTOR_HI:`FATC_VECTOR_LO]),
    .level(chk_ctx.level),
    .trap(vec_field_trap)
  );

  // Trap goes to level 2 under general trapping, otherwise level 1
  assign trap_target = (chk_ctx.el2_enabled && chk_ctx.trap_general_exc) ? 2'd2 : 2'd1;

  // Memory-mapped trace path bypasses the trace trap entirely
  assign trace_hit = chk_insn.trace_sysreg && !chk_insn.trace_mem_mapped && low_level &&
                     chk_ctx.trace_sysreg_impl && ctl_eff[`FATC_TRACE_BIT];
  assign trace_undef = chk_insn.trace_sysreg && !chk_insn.trace_mem_mapped &&
                       chk_ctx.level == 2'd0 && chk_ctx.trace_el0_forbidden;
  assign mat_hit = mat_field_trap && (chk_insn.matrix_insn || chk_insn.stream_vec_insn ||
                   chk_insn.stream_ctl_acc || chk_insn.stream_ctl_imm ||
                   chk_insn.matrix_ctl_acc);
  assign vec_hit = vec_field_trap && ((chk_insn.vec_insn && !chk_insn.stream_vec_insn) ||
                   chk_insn.vector_ctl_acc);
  assign flt_hit = flt_field_trap && (chk_insn.float_reg_acc || chk_insn.matrix_insn ||
                   chk_insn.vec_insn || chk_insn.stream_vec_insn);
  assign flt_undef = chk_insn.float_id_acc && chk_ctx.level == 2'd0;

  // Priority: undefined cases, then trace, matrix, vector, float
  always_comb begin
    res_d = '0;
    res_d.valid = chk_req;
    res_d.syndrome = `FATC_SYNDROME_ZERO;
    res_d.target = trap_target;
    if (trace_undef || flt_undef) begin
      res_d.undef = 1'b1;
      res_d.target = 2'd0;
    end else if (trace_hit) begin
      res_d.trap = 1'b1;
      if (!chk_insn.state_32) begin
        res_d.ec = `FATC_EC_SYSREG;
      end else if (chk_insn.trace_pair) begin
        res_d.ec = `FATC_EC_TRACE_MRR;
      end else begin
        res_d.ec = `FATC_EC_TRACE_MR;
      end
    end else if (mat_hit) begin
      res_d.trap = 1'b1;
      res_d.ec = `FATC_EC_MATRIX;
    end else if (vec_hit) begin
      res_d.trap = 1'b1;
      res_d.ec = `FATC_EC_VECTOR;
    end else if (flt_hit) begin
      res_d.trap = 1'b1;
      if (chk_insn.float_reg_acc && trap_target == 2'd2) begin
        res_d.ec = `FATC_EC_FLOAT_EL2;
      end else begin
        res_d.ec = `FATC_EC_FLOAT;
      end
    end else begin
      res_d.target = 2'd0;
    end
    res_d.suppress = res_d.trap || res_d.undef;
  end

  // Result register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chk_result <= '0;
    end else begin
      chk_result <= res_d;
    end
  end

  // Side effects allowed only for a clean check, so trapped accesses leave no trace
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      side_effect_en <= 1'b0;
    end else begin
      side_effect_en <= chk_req && !res_d.trap && !res_d.undef;
    end
  end
endmodule : fatc_top

// File: rtl/fatc_params.svh
// Offsets, field positions, encodings and reset values for feature access control
`ifndef FATC_PARAMS_SVH
`define FATC_PARAMS_SVH
`define FATC_TRACE_BIT 28
`define FATC_MATRIX_HI 25
`define FATC_MATRIX_LO 24
`define FATC_FLOAT_HI 21
`define FATC_FLOAT_LO 20
`define FATC_VECTOR_HI 17
`define FATC_VECTOR_LO 16
`define FATC_WR_MASK 64'h0000_0000_1333_0000
`define FATC_WR_MASK_NOTRACE 64'h0000_0000_0333_0000
`define FATC_RESET_VAL 64'h0000_0000_0000_0000
`define FATC_NV_MEM_OFFSET 12'h100
`define FATC_EC_SYSREG 6'h18
`define FATC_EC_TRACE_MR 6'h05
`define FATC_EC_TRACE_MRR 6'h0c
`define FATC_EC_MATRIX 6'h1d
`define FATC_EC_FLOAT 6'h07
`define FATC_EC_FLOAT_EL2 6'h00
`define FATC_EC_VECTOR 6'h19
`define FATC_SYNDROME_ZERO 25'h0000000
`define FATC_FIELD_OPEN 2'h3
`define FATC_FIELD_EL0_ONLY 2'h1
`endif

// File: rtl/fatc_pkg.sv
// Types shared by the feature access control block
package fatc_pkg;
  // Kind of instruction being checked
  typedef struct packed {
    logic trace_sysreg;
    logic trace_mem_mapped;
    logic trace_pair;
    logic state_32;
    logic matrix_insn;
    logic stream_vec_insn;
    logic vec_insn;
    logic stream_ctl_acc;
    logic stream_ctl_imm;
    logic matrix_ctl_acc;
    logic vector_ctl_acc;
    logic float_reg_acc;
    logic float_id_acc;
  } fatc_insn_t;

  // Execution context
  typedef struct packed {
    logic [1:0] level;
    logic el2_present;
    logic el2_enabled;
    logic el3_present;
    logic host_at_el2;
    logic trap_general_exc;
    logic el2_access_ctl_reg_trap;
    logic el3_access_ctl_reg_trap;
    logic el3_sdd_priority;
    logic [2:0] nested_virt;
    logic halted;
    logic debug_secure_disable;
    logic trace_sysreg_impl;
    logic trace_el0_forbidden;
  } fatc_ctx_t;

  // Outcome of a check
  typedef struct packed {
    logic valid;
    logic undef;
    logic trap;
    logic [1:0] target;
    logic [5:0] ec;
    logic [24:0] syndrome;
    logic suppress;
    logic redirect_nv;
    logic redirect_el2;
    logic [11:0] nv_offset;
  } fatc_result_t;

  typedef enum logic [2:0] {
    FATC_IDLE = 3'b001,
    FATC_HOLD = 3'b010,
    FATC_DONE = 3'b100
  } fatc_state_t;
endpackage : fatc_pkg

// File: rtl/fatc_field_decode.sv
// Decode of one two-bit enable field into a trap decision
module fatc_field_decode (
  input wire logic [1:0] field,
  input wire logic [1:0] level,
  output logic trap
);
  `include "fatc_params.svh"
  // Open field traps nothing, level-0-only traps level 0, others trap 0 and 1
  always_comb begin
    if (field == `FATC_FIELD_OPEN) begin
      trap = 1'b0;
    end else if (field == `FATC_FIELD_EL0_ONLY) begin
      trap = (level == 2'd0);
    end else begin
      trap = (level <= 2'd1);
    end
  end
endmodule : fatc_field_decode

// File: dv/fatc_top_properties.sv
// Port-level checker for the feature access control block
`include "fatc_params.svh"
module fatc_top_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chk_req,
  input wire fatc_pkg::fatc_insn_t chk_insn,
  input wire fatc_pkg::fatc_ctx_t chk_ctx,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [63:0] reg_wdata,
  input wire logic [63:0] el2_feature_trap,
  input wire logic [63:0] reg_rdata,
  input wire fatc_pkg::fatc_result_t chk_result,
  input wire fatc_pkg::fatc_result_t reg_result,
  input wire logic side_effect_en
);
  import fatc_pkg::*;
  // ----------------------------------------
  // Relations between requests and answers
  // ----------------------------------------
  logic acc;
  logic ovr;
  // Register access, and level 2 controls standing in for the fields
  assign acc = reg_rd || reg_wr;
  assign ovr = chk_ctx.el2_present && chk_ctx.el2_enabled && chk_ctx.host_at_el2
    && chk_ctx.trap_general_exc;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  el2_override_a: assert property (chk_req && ovr && !chk_ctx.level[1]
    && chk_insn == 13'h0040 && el2_feature_trap[21:20] == 2'h3
    |=> chk_result.trap == (!$past(el2_feature_trap[16])
    || ($past(chk_ctx.level) == 2'h0 && !$past(el2_feature_trap[17]))))
    else $error("override fields ignored");
  trace_pair_ec_a: assert property (chk_req && chk_insn.trace_sysreg && chk_insn.state_32
    && chk_insn.trace_pair ##1 chk_result.trap |-> chk_result.ec == `FATC_EC_TRACE_MRR)
    else $error("paired trace class");
  side_effect_gate_a: assert property (side_effect_en
    == (chk_result.valid && !chk_result.trap && !chk_result.undef)) else $error("side effect");
  mem_trace_free_a: assert property (chk_req && chk_insn == 13'h1800
    |=> chk_result.valid && !chk_result.trap) else $error("mapped trace trapped");
  matrix_syndrome_a: assert property (chk_req && chk_insn.matrix_insn ##1 chk_result.trap
    && chk_result.ec == `FATC_EC_MATRIX |-> chk_result.syndrome == `FATC_SYNDROME_ZERO)
    else $error("matrix syndrome");
  float_reg_ec_a: assert property (chk_req && chk_insn == 13'h0002 ##1 chk_result.trap
    |-> chk_result.ec == (chk_result.target == 2'h2 ? `FATC_EC_FLOAT_EL2 : `FATC_EC_FLOAT))
    else $error("float class");
  el0_reg_undef_a: assert property (acc && chk_ctx.level == 2'h0
    |=> reg_result.valid && reg_result.undef && !reg_result.trap) else $error("level 0 access");
  nv_redirect_a: assert property (acc && chk_ctx.level == 2'h1 && chk_ctx.el2_enabled
    && chk_ctx.nested_virt == 3'h7 && !chk_ctx.el2_access_ctl_reg_trap && !chk_ctx.el3_present
    |=> reg_result.redirect_nv && reg_result.nv_offset == `FATC_NV_MEM_OFFSET)
    else $error("nested redirect");
  el3_reg_trap_a: assert property (acc && chk_ctx.level == 2'h2 && chk_ctx.el3_present
    && chk_ctx.el3_access_ctl_reg_trap && !chk_ctx.halted
    |=> reg_result.trap && reg_result.target == 2'h3) else $error("level 3 trap");
  // Main scenarios reached
  trace_trap_c: cover property (chk_result.trap && chk_result.ec == `FATC_EC_SYSREG);
  nv_seen_c: cover property (reg_result.redirect_nv);
  el2_redirect_c: cover property (reg_result.redirect_el2);
endmodule : fatc_top_properties

bind fatc_top fatc_top_properties u_props (.clk_sys(clk_sys), .rst(rst), .chk_req(chk_req),
  .chk_insn(chk_insn), .chk_ctx(chk_ctx), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .el2_feature_trap(el2_feature_trap), .reg_rdata(reg_rdata),
  .chk_result(chk_result), .reg_result(reg_result), .side_effect_en(side_effect_en));

// File: dv/test_feature_access_trap_control.sv
// Self-checking bench for the feature access control block
`include "fatc_params.svh"
`define TB_CMP(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin err_total++; \
  $display("wrong value %s exp %h seen %h", nm, e, g); end end
module test_feature_access_trap_control;
  timeunit 1ns;
  timeprecision 1ps;
  import fatc_pkg::*;
  localparam logic [9:0] N = 10'h0;
  localparam logic [9:0] UD = 10'h200;
  localparam logic [12:0] MG [5] = '{13'h0100, 13'h0080, 13'h0020, 13'h0010, 13'h0008};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic chk_req = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_wr = 1'b0;
  logic [63:0] reg_wdata = '0;
  logic [63:0] el2_feature_trap = '0;
  logic [63:0] reg_rdata;
  logic [63:0] w;
  fatc_insn_t chk_insn = '0;
  fatc_ctx_t chk_ctx = '0;
  fatc_ctx_t c = '0;
  fatc_result_t chk_result;
  fatc_result_t reg_result;
  logic side_effect_en;
  int err_total = 0;
  int cmp_count = 0;
  logic [9:0] q_chk[$];
  logic [74:0] q_reg[$];
  logic [9:0] nc;
  logic [9:0] gc;
  logic [9:0] gr;
  logic [74:0] nr;
  always #10 clk_sys = ~clk_sys;
  fatc_top u_dut (.clk_sys(clk_sys), .rst(rst), .chk_req(chk_req), .chk_insn(chk_insn),
    .chk_ctx(chk_ctx), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .el2_feature_trap(el2_feature_trap), .reg_rdata(reg_rdata), .chk_result(chk_result),
    .reg_result(reg_result), .side_effect_en(side_effect_en));
  // Class and target only matter when a trap is taken
  function automatic logic [9:0] nm(logic [9:0] v);
    return (v[9] || !v[8]) ? {v[9:8], 8'h0} : v;
  endfunction : nm
  function automatic logic [9:0] ex(int u, int t, int g, logic [5:0] e);
    return {u[0], t[0], g[1:0], e};
  endfunction : ex
  // ----------------------------------------
  // Drivers and result watcher
  // ----------------------------------------
  task automatic ck(input logic [12:0] m, input logic [9:0] e);
    @(posedge clk_sys);
    chk_req <= 1'b1;
    chk_insn <= fatc_insn_t'(m);
    chk_ctx <= c;
    q_chk.push_back(e);
    @(posedge clk_sys);
    chk_req <= 1'b0;
  endtask : ck
  // Reads note the expected data, writes only the flags
  task automatic rg(input logic wr, input logic [63:0] d, input logic [9:0] e);
    @(posedge clk_sys);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_wdata <= d;
    chk_ctx <= c;
    q_reg.push_back({!wr, e, d});
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : rg
  // Oldest note is taken off as each answer appears
  always @(negedge clk_sys) begin
    if (chk_result.valid === 1'b1) begin
      nc = q_chk.size() ? q_chk.pop_front() : 'x;
      gc = {chk_result.undef, chk_result.trap, chk_result.target, chk_result.ec};
      `TB_CMP("check", nm(nc), nm(gc))
      `TB_CMP("side effect", !(nc[9] || nc[8]), side_effect_en)
    end
    if (reg_result.valid === 1'b1) begin
      nr = q_reg.size() ? q_reg.pop_front() : 'x;
      gr = {reg_result.undef, reg_result.trap, reg_result.target, reg_result.ec};
      `TB_CMP("access", nm(nr[73:64]), nm(gr))
      if (nr[74]) `TB_CMP("rdata", nr[63:0], reg_rdata)
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  // Cut a hang short well past the expected run of about 90 cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    err_total++;
    complete_run();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(99));
    c.el2_present = 1'b1;
    c.trace_sysreg_impl = 1'b1;
    c.level = 2'h1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    w = {$urandom, $urandom};
    rg(1'b1, w, N);
    rg(1'b0, w & `FATC_WR_MASK, N);
    rg(1'b1, 64'h0, N);
    foreach (MG[k]) ck(MG[k], ex(0, 1, 1, `FATC_EC_MATRIX));
    ck(13'h0040, ex(0, 1, 1, `FATC_EC_VECTOR));
    rg(1'b1, 64'h0022_0000, N);
    ck(13'h0004, ex(0, 1, 1, `FATC_EC_VECTOR));
    ck(13'h0002, ex(0, 1, 1, `FATC_EC_FLOAT));
    c.level = 2'h0;
    ck(13'h0001, UD);
    c.level = 2'h1;
    rg(1'b1, 64'h1031_0000, N);
    ck(13'h1000, ex(0, 1, 1, `FATC_EC_SYSREG));
    ck(13'h1200, ex(0, 1, 1, `FATC_EC_TRACE_MR));
    ck(13'h1600, ex(0, 1, 1, `FATC_EC_TRACE_MRR));
    ck(13'h1800, N);
    ck(13'h0040, N);
    c.level = 2'h0;
    ck(13'h0040, ex(0, 1, 1, `FATC_EC_VECTOR));
    c.trace_el0_forbidden = 1'b1;
    ck(13'h1000, UD);
    rg(1'b0, 64'h0, UD);
    c.level = 2'h1;
    rg(1'b1, 64'h0303_0000, N);
    ck(13'h0100, ex(0, 1, 1, `FATC_EC_FLOAT));
    ck(13'h1000, N);
    c.el2_enabled = 1'b1;
    c.trap_general_exc = 1'b1;
    ck(13'h0002, ex(0, 1, 2, `FATC_EC_FLOAT_EL2));
    c.host_at_el2 = 1'b1;
    el2_feature_trap <= 64'h0033_0000;
    ck(13'h0040, N);
    el2_feature_trap <= 64'h0030_0000;
    ck(13'h0040, ex(0, 1, 2, `FATC_EC_VECTOR));
    c.level = 2'h2;
    el2_feature_trap <= w & `FATC_WR_MASK;
    rg(1'b0, w & `FATC_WR_MASK, N);
    c.host_at_el2 = 1'b0;
    c.trap_general_exc = 1'b0;
    c.level = 2'h1;
    c.el2_access_ctl_reg_trap = 1'b1;
    rg(1'b1, 64'h0, ex(0, 1, 2, `FATC_EC_SYSREG));
    c.el2_access_ctl_reg_trap = 1'b0;
    c.nested_virt = 3'h7;
    rg(1'b1, 64'h0, N);
    c.nested_virt = 3'h0;
    rg(1'b0, 64'h0303_0000, N);
    c.level = 2'h2;
    c.el3_present = 1'b1;
    c.el3_access_ctl_reg_trap = 1'b1;
    rg(1'b0, 64'h0, ex(0, 1, 3, `FATC_EC_SYSREG));
    c.halted = 1'b1;
    c.debug_secure_disable = 1'b1;
    rg(1'b0, 64'h0, UD);
    // Early undefined outranks the level 2 trap when the priority option is on
    c.el3_sdd_priority = 1'b1;
    c.level = 2'h1;
    c.el2_access_ctl_reg_trap = 1'b1;
    rg(1'b0, 64'h0, UD);
    c.level = 2'h3;
    c.trace_sysreg_impl = 1'b0;
    rg(1'b1, 64'h1000_0000, N);
    rg(1'b0, 64'h0, N);
    repeat (3) @(posedge clk_sys);
    `TB_CMP("notes left", 0, q_chk.size() + q_reg.size())
    complete_run();
  end
endmodule : test_feature_access_trap_control
